//--- bench/ppfs_top_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ppfs_top_bench;
  import ppfs_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_sys;
  logic        resetn;
  logic [7:0]  s_awaddr;
  logic        s_awvalid;
  logic        s_awready;
  logic [31:0] s_wdata;
  logic [3:0]  s_wstrb;
  logic        s_wvalid;
  logic        s_wready;
  logic [1:0]  s_bresp;
  logic        s_bvalid;
  logic        s_bready;
  logic [7:0]  s_araddr;
  logic        s_arvalid;
  logic        s_arready;
  logic [31:0] s_rdata;
  logic [1:0]  s_rresp;
  logic        s_rvalid;
  logic        s_rready;
  logic [7:0]  p0_in;
  logic [7:0]  p0_out;
  logic [7:0]  p0_oe;
  logic [7:0]  p0_pullup;
  logic [3:0]  p1_in;
  logic [3:0]  p1_out;
  logic [3:0]  p1_oe;
  logic [3:0]  p1_pullup;
  logic [11:0] an_connect;
  logic [3:0]  key_in;
  logic [1:0]  last_resp;
  logic [2:0]  pv;
  int          bad_count;
  int          checks;
  int          cyc;

  ppfs_top dut
  (
    .clk_sys(clk_sys), .resetn(resetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup(p0_pullup),
    .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p1_pullup(p1_pullup),
    .an_connect(an_connect), .key_in(key_in)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // closing and hang guard
  // ---------------------------------------------------------------
  task automatic print_verdict();
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // whole run needs well under a thousand cycles; this ceiling only catches hangs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // address and data offered together, each dropped once its own channel takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    s_awaddr  <= a;
    s_awvalid <= 1'b1;
    s_wdata   <= d;
    s_wstrb   <= 4'h1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_awvalid && s_awready)
        s_awvalid <= 1'b0;
      if (s_wvalid && s_wready)
        s_wvalid <= 1'b0;
    end
    while (!(s_bvalid && s_bready) && n < 100);
    if (!(s_bvalid && s_bready))
      bad_count++;
    last_resp = s_bresp;
    s_bready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    int          n;
    logic [31:0] got;
    @(posedge clk_sys);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_arvalid && s_arready)
        s_arvalid <= 1'b0;
    end
    while (!(s_rvalid && s_rready) && n < 100);
    if (!(s_rvalid && s_rready))
      bad_count++;
    last_resp = s_rresp;
    got = s_rdata;
    s_rready <= 1'b0;
    `CHK(got, e)
  endtask

  task automatic p0_dir_set(input logic [31:0] d);
    wr(PPFS_A_PROTECT, 32'h0000_0004);
    wr(PPFS_A_P0_DIR, d);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
    {s_araddr, s_arvalid, s_rready} = '0;
    p0_in = 8'h00;
    p1_in = 4'h0;
    bad_count = 0;
    checks = 0;
    cyc = 0;
    resetn = 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    idle(2);
    `CHK(p0_oe, 8'h00)
    `CHK(an_connect, 12'h001)
    wr(PPFS_A_P3_DIR, 32'h0000_00FF);
    rd_chk(PPFS_A_P3_DIR, 32'h0000_00BB);
    wr(PPFS_A_P4_DIR, 32'h0000_00FF);
    rd_chk(PPFS_A_P4_DIR, 32'h0000_0038);
    wr(PPFS_A_P0_DIR, 32'h0000_00FF);
    rd_chk(PPFS_A_P0_DIR, 32'h0000_0000);
    // an intervening write, even to nothing, spends the unlock
    wr(PPFS_A_PROTECT, 32'h0000_0004);
    wr(8'h40, 32'h0000_00FF);
    `CHK(last_resp, PPFS_SLVERR)
    wr(PPFS_A_P0_DIR, 32'h0000_00FF);
    rd_chk(PPFS_A_P0_DIR, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    `CHK(last_resp, PPFS_SLVERR)
    p0_dir_set(32'h0000_00A5);
    rd_chk(PPFS_A_P0_DIR, 32'h0000_00A5);
    wr(PPFS_A_P0_DIR, 32'h0000_0000);
    rd_chk(PPFS_A_P0_DIR, 32'h0000_00A5);
    `CHK(p0_oe, 8'hA5)
    // mixed directions: read merges latch and filtered pins
    @(posedge clk_sys);
    p0_in <= 8'h0F;
    wr(PPFS_A_P0_DATA, 32'h0000_003C);
    idle(8);
    `CHK(p0_out, 8'h3C)
    rd_chk(PPFS_A_P0_DATA, 32'h0000_002E);
    p0_dir_set(32'h0000_0000);
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(PPFS_A_CONV, 32'(ch));
      idle(2);
      `CHK(an_connect, 12'h001 << ch)
    end
    p0_dir_set(32'h0000_0001);
    idle(2);
    `CHK(an_connect, 12'h000)
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(PPFS_A_CONV, 32'h0000_0010 | 32'(ch));
      idle(2);
      `CHK(an_connect, (ch >= 4) ? (12'h001 << (ch + 4)) : 12'h000)
    end
    // key enable wins over the analog route still selected on pin 3
    @(posedge clk_sys);
    p1_in <= 4'hA;
    wr(PPFS_A_KEY_EN, 32'h0000_000F);
    idle(8);
    `CHK(an_connect, 12'h000)
    `CHK(key_in, 4'hA)
    wr(PPFS_A_P1_DIR, 32'h0000_0003);
    idle(8);
    `CHK(key_in, 4'h8)
    `CHK(p1_oe, 4'h3)
    wr(PPFS_A_P1_DATA, 32'h0000_0005);
    idle(2);
    `CHK(p1_out, 4'h5)
    rd_chk(PPFS_A_P1_DATA, 32'h0000_0009);
    for (int i = 0; i < 8; i++)
    begin
      pv = i[2:0];
      wr(PPFS_A_PULLUP, 32'(i));
      idle(2);
      `CHK(p0_pullup, {{4{pv[1]}}, {4{pv[0]}}} & 8'hFE)
      `CHK(p1_pullup, {4{pv[2]}} & 4'hC)
    end
    print_verdict();
  end
endmodule

//--- core/ppfs_top.sv
`timescale 1ns/1ps
// Function
// - port 3 direction bits 2 and 6 absent: read zero, writes ignored.
// - port 4 direction bits 0-2, 6, 7 absent: read zero, writes ignored.
// - port 0 direction written only by the write right after setting unlock.
// - port 0 pin 0 is analog 7 for dir 0, channel 111, group 0.
// - group 0, dir 0: channels 110/101/100 route port 0 pins 1-3 to 6-4.
// - group 0, dir 0: channels 011..000 route port 0 pins 4-7 to 3-0.
// - group 1, dir 0, key enable clear: channels 100..111 route port 1 pins 0-3 to 8-11.
// - port 1 pins 0-3 are key inputs when dir 0 and key enable set.
// - port 0 input pull-up from nibble bit: bit 0 low, bit 1 high.
// - port 1 pins 0-3 input pull-up when pull-up bit 2 is set.
// - data read gives pin in input mode, latch in output mode.
module ppfs_top
(
  input  wire logic                           clk_sys,     // system clock
  input  wire logic                           resetn,      // async reset
  input  wire logic [ppfs_pkg::PPFS_AW-1:0]   s_awaddr,    // write address
  input  wire logic                           s_awvalid,   // write address valid
  output logic                                s_awready,   // write address ready
  input  wire logic [31:0]                    s_wdata,     // write data
  input  wire logic [3:0]                     s_wstrb,     // write strobes
  input  wire logic                           s_wvalid,    // write data valid
  output logic                                s_wready,    // write data ready
  output logic [1:0]                          s_bresp,     // write response
  output logic                                s_bvalid,    // write response valid
  input  wire logic                           s_bready,    // write response ready
  input  wire logic [ppfs_pkg::PPFS_AW-1:0]   s_araddr,    // read address
  input  wire logic                           s_arvalid,   // read address valid
  output logic                                s_arready,   // read address ready
  output logic [31:0]                         s_rdata,     // read data
  output logic [1:0]                          s_rresp,     // read response
  output logic                                s_rvalid,    // read data valid
  input  wire logic                           s_rready,    // read data ready
  input  wire logic [ppfs_pkg::PPFS_P0_W-1:0] p0_in,       // port 0 pin levels
  output logic [ppfs_pkg::PPFS_P0_W-1:0]      p0_out,      // port 0 drive value
  output logic [ppfs_pkg::PPFS_P0_W-1:0]      p0_oe,       // port 0 output enable
  output logic [ppfs_pkg::PPFS_P0_W-1:0]      p0_pullup,   // port 0 pull-up on
  input  wire logic [ppfs_pkg::PPFS_P1_W-1:0] p1_in,       // port 1 low pin levels
  output logic [ppfs_pkg::PPFS_P1_W-1:0]      p1_out,      // port 1 drive value
  output logic [ppfs_pkg::PPFS_P1_W-1:0]      p1_oe,       // port 1 output enable
  output logic [ppfs_pkg::PPFS_P1_W-1:0]      p1_pullup,   // port 1 pull-up on
  output logic [ppfs_pkg::PPFS_AN_W-1:0]      an_connect,  // analog channel routed
  output logic [ppfs_pkg::PPFS_P1_W-1:0]      key_in       // key inputs, filtered
);
  import ppfs_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [PPFS_P0_W-1:0] port0_latch_q;
  logic [PPFS_P1_W-1:0] port1_latch_q;
  logic [PPFS_P0_W-1:0] port0_direction_q;
  logic [PPFS_P1_W-1:0] port1_direction_q;
  logic [7:0]           port3_direction_q;
  logic [7:0]           port4_direction_q;
  logic                 unlock_q;
  logic [7:0]           conv_ctrl_q;
  logic [PPFS_P1_W-1:0] key_enable_q;
  logic [2:0]           pullup_control_q;
  logic                 aw_have_q;
  logic                 w_have_q;
  logic [PPFS_AW-1:0]   waddr_q;
  logic [7:0]           wbyte_q;
  logic                 wlane_q;
  logic [PPFS_P0_W-1:0] p0_s1_q, p0_s2_q, p0_s3_q, p0_pin_q;
  logic [PPFS_P1_W-1:0] p1_s1_q, p1_s2_q, p1_s3_q, p1_pin_q;
  logic                 do_write;
  logic [2:0]           ch_sel;
  logic                 gsel;

  assign do_write = aw_have_q && w_have_q && !s_bvalid;
  assign ch_sel   = conv_ctrl_q[2:0];
  assign gsel     = conv_ctrl_q[PPFS_GSEL_BIT];

  function automatic logic known(input logic [PPFS_AW-1:0] a);
    known = (a == PPFS_A_P0_DATA) || (a == PPFS_A_P1_DATA) || (a == PPFS_A_P0_DIR)
         || (a == PPFS_A_P1_DIR) || (a == PPFS_A_P3_DIR) || (a == PPFS_A_P4_DIR)
         || (a == PPFS_A_PROTECT) || (a == PPFS_A_CONV) || (a == PPFS_A_KEY_EN)
         || (a == PPFS_A_PULLUP);
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers: a change counts once stages 2 and 3 agree
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      {p0_s1_q, p0_s2_q, p0_s3_q, p0_pin_q} <= '0;
      {p1_s1_q, p1_s2_q, p1_s3_q, p1_pin_q} <= '0;
    end
    else
    begin
      p0_s1_q <= p0_in;
      p0_s2_q <= p0_s1_q;
      p0_s3_q <= p0_s2_q;
      p1_s1_q <= p1_in;
      p1_s2_q <= p1_s1_q;
      p1_s3_q <= p1_s2_q;
      for (int i = 0; i < PPFS_P0_W; i++)
      begin
        if (p0_s2_q[i] == p0_s3_q[i])
          p0_pin_q[i] <= p0_s3_q[i];
      end
      for (int i = 0; i < PPFS_P1_W; i++)
      begin
        if (p1_s2_q[i] == p1_s3_q[i])
          p1_pin_q[i] <= p1_s3_q[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // write channel: address and data taken in either order
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      {s_awready, s_wready, aw_have_q, w_have_q, wlane_q, s_bvalid} <= '0;
      waddr_q <= '0;
      wbyte_q <= PPFS_RST8;
      s_bresp <= PPFS_OKAY;
    end
    else
    begin
      if (s_awvalid && s_awready)
      begin
        s_awready <= 1'b0;
        aw_have_q <= 1'b1;
        waddr_q   <= s_awaddr;
      end
      else if (!aw_have_q && !s_bvalid)
        s_awready <= 1'b1;
      if (s_wvalid && s_wready)
      begin
        s_wready <= 1'b0;
        w_have_q <= 1'b1;
        wbyte_q  <= s_wdata[7:0];
        wlane_q  <= s_wstrb[0];
      end
      else if (!w_have_q && !s_bvalid)
        s_wready <= 1'b1;
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= known(waddr_q) ? PPFS_OKAY : PPFS_SLVERR;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register updates; only byte lane 0 carries data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      {port0_latch_q, port1_latch_q, port0_direction_q, port1_direction_q} <= '0;
      {unlock_q, key_enable_q, pullup_control_q} <= '0;
      port3_direction_q <= PPFS_RST8;
      port4_direction_q <= PPFS_RST8;
      conv_ctrl_q       <= PPFS_RST8;
    end
    else if (do_write)
    begin
      // unlock lives exactly one write: any later write drops it, except another unlock write
      unlock_q <= 1'b0;
      if (wlane_q)
      begin
        if (waddr_q == PPFS_A_P0_DATA)
          port0_latch_q <= wbyte_q;
        else if (waddr_q == PPFS_A_P1_DATA)
          port1_latch_q <= wbyte_q[PPFS_P1_W-1:0];
        else if (waddr_q == PPFS_A_P0_DIR)
        begin
          if (unlock_q)
            port0_direction_q <= wbyte_q;
        end
        else if (waddr_q == PPFS_A_P1_DIR)
          port1_direction_q <= wbyte_q[PPFS_P1_W-1:0];
        else if (waddr_q == PPFS_A_P3_DIR)
          port3_direction_q <= wbyte_q & PPFS_P3_MASK;
        else if (waddr_q == PPFS_A_P4_DIR)
          port4_direction_q <= wbyte_q & PPFS_P4_MASK;
        else if (waddr_q == PPFS_A_PROTECT)
          unlock_q <= wbyte_q[PPFS_UNLOCK_BIT];
        else if (waddr_q == PPFS_A_CONV)
          conv_ctrl_q <= wbyte_q;
        else if (waddr_q == PPFS_A_KEY_EN)
          key_enable_q <= wbyte_q[PPFS_P1_W-1:0];
        else if (waddr_q == PPFS_A_PULLUP)
          pullup_control_q <= wbyte_q[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel: one cycle from address to data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= '0;
      s_rresp   <= PPFS_OKAY;
    end
    else
    begin
      if (s_arvalid && s_arready)
      begin
        s_arready <= 1'b0;
        s_rvalid  <= 1'b1;
        s_rresp   <= known(s_araddr) ? PPFS_OKAY : PPFS_SLVERR;
        s_rdata   <= '0;
        if (s_araddr == PPFS_A_P0_DATA)
          s_rdata[7:0] <= (port0_direction_q & port0_latch_q)
                        | (~port0_direction_q & p0_pin_q);
        else if (s_araddr == PPFS_A_P1_DATA)
          s_rdata[PPFS_P1_W-1:0] <= (port1_direction_q & port1_latch_q)
                                  | (~port1_direction_q & p1_pin_q);
        else if (s_araddr == PPFS_A_P0_DIR)
          s_rdata[7:0] <= port0_direction_q;
        else if (s_araddr == PPFS_A_P1_DIR)
          s_rdata[PPFS_P1_W-1:0] <= port1_direction_q;
        else if (s_araddr == PPFS_A_P3_DIR)
          s_rdata[7:0] <= port3_direction_q & PPFS_P3_MASK;
        else if (s_araddr == PPFS_A_P4_DIR)
          s_rdata[7:0] <= port4_direction_q & PPFS_P4_MASK;
        else if (s_araddr == PPFS_A_PROTECT)
          s_rdata[PPFS_UNLOCK_BIT] <= unlock_q;
        else if (s_araddr == PPFS_A_CONV)
          s_rdata[7:0] <= conv_ctrl_q;
        else if (s_araddr == PPFS_A_KEY_EN)
          s_rdata[PPFS_P1_W-1:0] <= key_enable_q;
        else if (s_araddr == PPFS_A_PULLUP)
          s_rdata[2:0] <= pullup_control_q;
      end
      else if (!s_rvalid)
        s_arready <= 1'b1;
      if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin function selection, registered
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      {p0_out, p0_oe, p0_pullup, p1_out, p1_oe, p1_pullup} <= '0;
      {an_connect, key_in} <= '0;
    end
    else
    begin
      p0_out <= port0_latch_q;
      p0_oe  <= port0_direction_q;
      p1_out <= port1_latch_q;
      p1_oe  <= port1_direction_q;
      for (int j = 0; j < PPFS_P0_W; j++)
      begin
        p0_pullup[j] <= !port0_direction_q[j] && ((j < PPFS_NIBBLE) ?
          pullup_control_q[PPFS_PU_P0_LO] : pullup_control_q[PPFS_PU_P0_HI]);
        // pin j answers channel 7-j in group 0
        an_connect[PPFS_P0_CH_TOP-j] <= !port0_direction_q[j] && !gsel
          && (ch_sel == 3'(PPFS_P0_CH_TOP - j));
      end
      for (int j = 0; j < PPFS_P1_W; j++)
      begin
        p1_pullup[j] <= !port1_direction_q[j] && pullup_control_q[PPFS_PU_P1_LO];
        // key input takes the pin whatever the converter settings
        key_in[j] <= !port1_direction_q[j] && key_enable_q[j] && p1_pin_q[j];
        an_connect[PPFS_P1_AN_BASE+j] <= !port1_direction_q[j] && gsel
          && !key_enable_q[j] && (ch_sel == 3'(PPFS_P1_CH_BASE + j));
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence unlock_write_s;
    do_write && wlane_q && waddr_q == PPFS_A_PROTECT && wbyte_q[PPFS_UNLOCK_BIT];
  endsequence
  sequence other_write_s;
    do_write && !(wlane_q && waddr_q == PPFS_A_PROTECT && wbyte_q[PPFS_UNLOCK_BIT]);
  endsequence

  p3_unimpl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port3_direction_q & ~PPFS_P3_MASK) == '0) else $error("p3 absent bit set");
  p4_unimpl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (port4_direction_q & ~PPFS_P4_MASK) == '0) else $error("p4 absent bit set");
  dir_lock_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (do_write && waddr_q == PPFS_A_P0_DIR && !unlock_q) |=> $stable(port0_direction_q))
    else $error("locked direction changed");
  unlock_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    unlock_write_s |=> unlock_q) else $error("unlock not set");
  unlock_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    other_write_s |=> !unlock_q) else $error("unlock outlived a write");
  dir_guard_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !$stable(port0_direction_q) |-> $past(unlock_q) && $past(do_write))
    else $error("direction change without unlock");
  an_pin0_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!port0_direction_q[0] && ch_sel == 3'h7 && !gsel) |=> an_connect[7])
    else $error("pin 0 not analog 7");
  an_onehot_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $onehot0(an_connect[PPFS_P0_CH_TOP:0])) else $error("two group 0 routes");
  an_group1_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    gsel && !port1_direction_q[1] && !key_enable_q[1] && ch_sel == 3'h5 |=> an_connect[9])
    else $error("pin 1 not analog 9");
  key_path_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    key_in[0] |-> $past(key_enable_q[0]) && !$past(port1_direction_q[0]))
    else $error("key input without enable");
  pullup_p0_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    p0_pullup[5] |-> $past(pullup_control_q[PPFS_PU_P0_HI]) && !$past(port0_direction_q[5]))
    else $error("port 0 pull-up wrong");
  pullup_p1_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!port1_direction_q[2] && pullup_control_q[PPFS_PU_P1_LO]) |=> p1_pullup[2])
    else $error("port 1 pull-up missing");
  read_data_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_arvalid && s_arready && s_araddr == PPFS_A_P0_DATA && port0_direction_q == 8'hFF)
    |=> s_rvalid && s_rdata[7:0] == $past(port0_latch_q)) else $error("latch readback");
  drive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    p0_oe == $past(port0_direction_q) && p0_out == $past(port0_latch_q))
    else $error("port 0 drive mismatch");
endmodule

//--- include/ppfs_pkg.sv
package ppfs_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] PPFS_A_P0_DATA  = 8'h00;
  localparam logic [7:0] PPFS_A_P1_DATA  = 8'h04;
  localparam logic [7:0] PPFS_A_P0_DIR   = 8'h08;
  localparam logic [7:0] PPFS_A_P1_DIR   = 8'h0C;
  localparam logic [7:0] PPFS_A_P3_DIR   = 8'h10;
  localparam logic [7:0] PPFS_A_P4_DIR   = 8'h14;
  localparam logic [7:0] PPFS_A_PROTECT  = 8'h18;
  localparam logic [7:0] PPFS_A_CONV     = 8'h1C;
  localparam logic [7:0] PPFS_A_KEY_EN   = 8'h20;
  localparam logic [7:0] PPFS_A_PULLUP   = 8'h24;
  // ---------------------------------------------------------------
  // widths and field layout
  // ---------------------------------------------------------------
  localparam int         PPFS_AW         = 8;
  localparam int         PPFS_P0_W       = 8;
  localparam int         PPFS_P1_W       = 4;
  localparam int         PPFS_AN_W       = 12;
  localparam int         PPFS_P1_AN_BASE = 8;
  localparam int         PPFS_P1_CH_BASE = 4;
  localparam int         PPFS_P0_CH_TOP  = 7;
  localparam int         PPFS_UNLOCK_BIT = 2;
  localparam int         PPFS_GSEL_BIT   = 4;
  localparam int         PPFS_PU_P0_LO   = 0;
  localparam int         PPFS_PU_P0_HI   = 1;
  localparam int         PPFS_PU_P1_LO   = 2;
  localparam int         PPFS_NIBBLE     = 4;
  // implemented direction bits; others read as zero
  localparam logic [7:0] PPFS_P3_MASK    = 8'hBB;
  localparam logic [7:0] PPFS_P4_MASK    = 8'h38;
  localparam logic [7:0] PPFS_RST8       = 8'h00;
  localparam logic [1:0] PPFS_OKAY       = 2'h0;
  localparam logic [1:0] PPFS_SLVERR     = 2'h2;
endpackage
